// File: rtl/ccso_pkg.sv
package ccso_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_SLEW = 16'h1c16;
	localparam logic [15:0] IDX_SRC = 16'h1c17;
	localparam logic [15:0] IDX_STAT3 = 16'h1c18;
	localparam logic [15:0] IDX_SERIAL = 16'h1c19;
	localparam logic [15:0] IDX_INFO = 16'h1c1a;

	// field positions and widths
	localparam int SLEW_LSB = 0;
	localparam int SLEW_W = 2;
	localparam int SRC_LSB = 0;
	localparam int SRC_W = 3;
	localparam int OFF_BIT = 2;
	localparam int SPI_LSB = 0;
	localparam int I2C_LSB = 8;
	localparam int DIV_W = 8;
	localparam int INFO_SEL_BIT = 0;
	localparam int INFO_BOOT_BIT = 1;
	localparam int INFO_BYP_BIT = 2;

	// reset values
	localparam logic [15:0] SLEW_RST = 16'h0000;
	localparam logic [15:0] SRC_RST = 16'h0000;
	localparam logic [15:0] STAT3_RST = 16'h0000;
	localparam logic [15:0] SERIAL_RST = 16'h0000;

	// source codes below the generator clocks
	localparam logic [2:0] SRC_REF = 3'h0;
	localparam logic [2:0] SRC_RTC = 3'h1;
	localparam int SRC_GEN0 = 2;

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYNC_SETTLE_CYC = 2;
	localparam int BOOT_START_NS = 2000;
	localparam int BOOT_START_CYC = (BOOT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// assumed boot input frequencies and target serial rates
	localparam int FIN0_HZ = 11289600;
	localparam int FIN1_HZ = 12000000;
	localparam int FIN2_HZ = 12288000;
	localparam int SPI_HZ = 500000;
	localparam int I2C_HZ = 400000;

	typedef enum logic [1:0] {
		ST_SETTLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_BOOT = 2'b10,
		ST_RUN = 2'b11
	} ccso_state_t;

	// rounding up keeps the serial clock at or below its target rate
	function automatic logic [7:0] boot_div(input logic [1:0] fsel, input int rate);
		int f;
		f = (fsel == 2'h0) ? FIN0_HZ : ((fsel == 2'h2) ? FIN2_HZ : FIN1_HZ);
		boot_div = 8'((f + rate - 1) / rate);
	endfunction : boot_div

endpackage : ccso_pkg

// File: rtl/ccso_sync.sv
`timescale 1ns/1ps
module ccso_sync #(
	parameter int W = 1
) (
	// clock, reset and enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta;

	// meta is read by q_o only
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta <= '0;
			q_o <= '0;
		end
		else if (ce_i)
		begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule : ccso_sync

// File: rtl/ccso_top.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - the debug clock output shows the reference, the RTC clock or one of the clock-generator clocks picked by the source field.
// - software sets the output slew rate through the slew control register at index 0x1c16.
// - the output disable bit in status word three turns the pin off and leaves it high impedance.
// - after reset the pin is driven until boot starts, then boot sets the disable bit to 1.
// - with the select pin high the external input is the reference of the clock generator.
// - with the select pin low the 32 kHz oscillator drives both RTC and generator, external ignored.
// - at boot with the external input selected the PLL is bypassed for an assumed input frequency.
// - boot sets the serial dividers for 500 kHz SPI and 400 kHz I2C from that assumed frequency.
// - with the select pin high the 32 kHz oscillator clocks only the RTC timer.
module ccso_top #(
	parameter int NUM_GEN = 4,
	parameter logic [1:0] BOOT_FREQ_SEL = 2'h1
) (
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// avalon-mm slave, byte addressed
	input wire logic [15:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// pins and clock sources
	input wire logic external_reference_input_i,
	input wire logic rtc_osc_i,
	input wire logic clock_select_i,
	input wire logic [NUM_GEN-1:0] gen_clk_i,
	// debug clock output pin
	output logic debug_clock_output_pin_o,
	output logic debug_clock_output_pin_oe_n_o,
	output logic [1:0] debug_clock_output_slew_o,
	// clock generator side
	output logic reference_clock_o,
	output logic rtc_timer_clock_o,
	output logic pll_bypass_o,
	output logic [7:0] spi_clk_div_o,
	output logic [7:0] i2c_clk_div_o
);

	localparam int SW = NUM_GEN + 3;

	logic [SW-1:0] pins_sync;
	logic ext_s;
	logic rtc_s;
	logic sel_s;
	logic [NUM_GEN-1:0] gen_s;

	logic [15:0] output_slew_control_reg;
	logic [15:0] output_source_control_reg;
	logic [15:0] cpu_status_word_three;
	logic [15:0] serial_rate_reg;

	ccso_pkg::ccso_state_t state;
	ccso_pkg::ccso_state_t next_state;
	logic [11:0] cnt;
	logic sel_latched;
	logic boot_done;
	logic ref_sel;

	logic req;
	logic wr_take;
	logic [31:0] next_rdata;
	logic [15:0] next_slew;
	logic [15:0] next_src;
	logic [15:0] next_stat3;
	logic [15:0] next_serial;

	function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
		hit = (addr == {idx[13:0], 2'b00});
	endfunction : hit

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	function automatic logic pick_src(input logic [2:0] sel, input logic refc,
		input logic rtcc, input logic [NUM_GEN-1:0] gen);
		logic v;
		v = 1'b0;
		if (sel == ccso_pkg::SRC_REF)
			v = refc;
		else if (sel == ccso_pkg::SRC_RTC)
			v = rtcc;
		for (int k = 0; k < NUM_GEN; k++)
		begin
			if (int'(sel) == k + ccso_pkg::SRC_GEN0)
				v = gen[k];
		end
		pick_src = v;
	endfunction : pick_src

	// every pin and foreign clock is sampled through two flops
	ccso_sync #(
		.W(SW)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.d_i({gen_clk_i, clock_select_i, rtc_osc_i, external_reference_input_i}),
		.q_o(pins_sync)
	);

	assign ext_s = pins_sync[0];
	assign rtc_s = pins_sync[1];
	assign sel_s = pins_sync[2];
	assign gen_s = pins_sync[SW-1:3];

	// bus handshake: one wait state, then the transfer completes
	assign req = avs_read_i | avs_write_i;
	assign wr_take = avs_write_i & ~avs_waitrequest_o;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			avs_waitrequest_o <= 1'b1;
		else if (ce_i)
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
	end

	always_comb
	begin
		next_rdata = '0;
		if (hit(avs_address_i, ccso_pkg::IDX_SLEW))
			next_rdata[15:0] = output_slew_control_reg;
		else if (hit(avs_address_i, ccso_pkg::IDX_SRC))
			next_rdata[15:0] = output_source_control_reg;
		else if (hit(avs_address_i, ccso_pkg::IDX_STAT3))
			next_rdata[15:0] = cpu_status_word_three;
		else if (hit(avs_address_i, ccso_pkg::IDX_SERIAL))
			next_rdata[15:0] = serial_rate_reg;
		else if (hit(avs_address_i, ccso_pkg::IDX_INFO))
		begin
			next_rdata[ccso_pkg::INFO_SEL_BIT] = sel_latched;
			next_rdata[ccso_pkg::INFO_BOOT_BIT] = boot_done;
			next_rdata[ccso_pkg::INFO_BYP_BIT] = pll_bypass_o;
		end
	end

	// read data is prepared in the wait cycle and stands at completion
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			avs_readdata_o <= '0;
		else if (ce_i && avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= next_rdata;
	end

	// register writes
	always_comb
	begin
		next_slew = output_slew_control_reg;
		next_src = output_source_control_reg;
		next_stat3 = cpu_status_word_three;
		next_serial = serial_rate_reg;
		if (wr_take && hit(avs_address_i, ccso_pkg::IDX_SLEW))
			next_slew = merge(output_slew_control_reg, avs_writedata_i, avs_byteenable_i);
		if (wr_take && hit(avs_address_i, ccso_pkg::IDX_SRC))
			next_src = merge(output_source_control_reg, avs_writedata_i, avs_byteenable_i);
		if (wr_take && hit(avs_address_i, ccso_pkg::IDX_STAT3))
			next_stat3 = merge(cpu_status_word_three, avs_writedata_i, avs_byteenable_i);
		if (wr_take && hit(avs_address_i, ccso_pkg::IDX_SERIAL))
			next_serial = merge(serial_rate_reg, avs_writedata_i, avs_byteenable_i);
		// the boot step wins over a software write in the same cycle
		if (state == ccso_pkg::ST_BOOT)
		begin
			next_stat3[ccso_pkg::OFF_BIT] = 1'b1;
			if (sel_latched)
			begin
				next_serial[ccso_pkg::SPI_LSB +: ccso_pkg::DIV_W] =
					ccso_pkg::boot_div(BOOT_FREQ_SEL, ccso_pkg::SPI_HZ);
				next_serial[ccso_pkg::I2C_LSB +: ccso_pkg::DIV_W] =
					ccso_pkg::boot_div(BOOT_FREQ_SEL, ccso_pkg::I2C_HZ);
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			output_slew_control_reg <= ccso_pkg::SLEW_RST;
			output_source_control_reg <= ccso_pkg::SRC_RST;
			cpu_status_word_three <= ccso_pkg::STAT3_RST;
			serial_rate_reg <= ccso_pkg::SERIAL_RST;
		end
		else if (ce_i)
		begin
			output_slew_control_reg <= next_slew;
			output_source_control_reg <= next_src;
			cpu_status_word_three <= next_stat3;
			serial_rate_reg <= next_serial;
		end
	end

	assign debug_clock_output_slew_o =
		output_slew_control_reg[ccso_pkg::SLEW_LSB +: ccso_pkg::SLEW_W];
	assign spi_clk_div_o = serial_rate_reg[ccso_pkg::SPI_LSB +: ccso_pkg::DIV_W];
	assign i2c_clk_div_o = serial_rate_reg[ccso_pkg::I2C_LSB +: ccso_pkg::DIV_W];

	// startup sequence: settle synchroniser, catch the strap, wait, boot step
	always_comb
	begin
		next_state = state;
		unique case (state)
			ccso_pkg::ST_SETTLE:
				if (cnt == 12'(ccso_pkg::SYNC_SETTLE_CYC - 1))
					next_state = ccso_pkg::ST_WAIT;
			ccso_pkg::ST_WAIT:
				if (cnt == 12'(ccso_pkg::BOOT_START_CYC - 1))
					next_state = ccso_pkg::ST_BOOT;
			ccso_pkg::ST_BOOT:
				next_state = ccso_pkg::ST_RUN;
			ccso_pkg::ST_RUN:
				next_state = ccso_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ccso_pkg::ST_SETTLE;
			cnt <= '0;
		end
		else if (ce_i)
		begin
			state <= next_state;
			if (next_state != state)
				cnt <= '0;
			else if (state != ccso_pkg::ST_RUN)
				cnt <= cnt + 12'h001;
		end
	end

	// strap caught once; later pin changes are not followed
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			sel_latched <= 1'b0;
		// taken on the first wait cycle, once the second sync flop holds the pin
		else if (ce_i && state == ccso_pkg::ST_WAIT && cnt == 12'h000)
			sel_latched <= sel_s;
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			boot_done <= 1'b0;
			pll_bypass_o <= 1'b0;
		end
		else if (ce_i && state == ccso_pkg::ST_BOOT)
		begin
			boot_done <= 1'b1;
			pll_bypass_o <= sel_latched;
		end
	end

	// reference mux; no glitch protection since the select never moves after startup
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ref_sel <= 1'b0;
			reference_clock_o <= 1'b0;
			rtc_timer_clock_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ref_sel <= sel_latched ? ext_s : rtc_s;
			reference_clock_o <= ref_sel;
			rtc_timer_clock_o <= rtc_s;
		end
	end

	// debug pin: source pick and drive enable
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			debug_clock_output_pin_o <= 1'b0;
			debug_clock_output_pin_oe_n_o <= 1'b0;
		end
		else if (ce_i)
		begin
			debug_clock_output_pin_o <= pick_src(
				output_source_control_reg[ccso_pkg::SRC_LSB +: ccso_pkg::SRC_W],
				ref_sel, rtc_s, gen_s);
			debug_clock_output_pin_oe_n_o <= cpu_status_word_three[ccso_pkg::OFF_BIT];
		end
	end

endmodule : ccso_top

// File: dv/ccso_clk_model.sv
`timescale 1ns/1ps
module ccso_clk_model (
	// clock and strap
	input wire logic mclk_i,
	input wire logic sel_i,
	// source clocks
	output logic ext_o,
	output logic rtc_o,
	output logic [3:0] gen_o
);
	int c = 0;
	// locked to mclk so that periods can be measured exactly
	always @(posedge mclk_i)
		c <= c + 1;
	// grounded when the on-chip oscillator is in use
	assign ext_o = sel_i & ((c / 7) % 2 == 1);
	assign rtc_o = (c / 16) % 2 == 1;
	always_comb
		for (int k = 0; k < 4; k++)
			gen_o[k] = (c / (k + 2)) % 2 == 1;
endmodule : ccso_clk_model

// File: dv/ccso_monitor.sv
`timescale 1ns/1ps
module ccso_monitor (
	// clock, reset, bus
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [15:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	// clocks and pin
	input wire logic external_reference_input_i,
	input wire logic rtc_osc_i,
	input wire logic clock_select_i,
	input wire logic debug_clock_output_pin_oe_n_o,
	input wire logic [1:0] debug_clock_output_slew_o,
	input wire logic reference_clock_o,
	input wire logic rtc_timer_clock_o
);
	logic [3:0] age;
	logic tk;
	logic w0;
	logic oe_n;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	assign tk = (avs_read_i | avs_write_i) & !avs_waitrequest_o;
	assign w0 = avs_write_i & !avs_waitrequest_o & avs_byteenable_i[0];
	assign oe_n = debug_clock_output_pin_oe_n_o;
	// muxes are judged only after strap and synchronisers settle
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			age <= 4'h0;
		else if (age != 4'hf)
			age <= age + 4'h1;
	end
	property p_wait;
		tk |=> avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest low twice");
	property p_slew;
		w0 && avs_address_i == 16'h7058
			|=> debug_clock_output_slew_o == $past(avs_writedata_i[1:0]);
	endproperty
	a_slew: assert property (p_slew) else $error("slew not taken");
	property p_drv;
		$fell(rst_i) |-> !oe_n [*8];
	endproperty
	a_drv: assert property (p_drv) else $error("pin not driven after reset");
	property p_boot;
		$fell(rst_i) |-> ##[95:110] oe_n;
	endproperty
	a_boot: assert property (p_boot) else $error("boot did not turn pin off");
	property p_off;
		w0 && avs_address_i == 16'h7060 && avs_writedata_i[2] |-> ##[1:2] oe_n;
	endproperty
	a_off: assert property (p_off) else $error("disable bit ignored");
	property p_ext;
		age == 4'hf && clock_select_i && $rose(external_reference_input_i)
			|-> ##[2:5] reference_clock_o;
	endproperty
	a_ext: assert property (p_ext) else $error("reference not external");
	property p_osc;
		age == 4'hf && !clock_select_i && $rose(rtc_osc_i) |-> ##[2:5] reference_clock_o;
	endproperty
	a_osc: assert property (p_osc) else $error("reference not oscillator");
	property p_tmr;
		age == 4'hf && $rose(rtc_osc_i) |-> ##[2:5] rtc_timer_clock_o;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer clock lost");
	c_read: cover property (tk && avs_read_i);
	c_off: cover property ($rose(oe_n));
	c_osc: cover property (!clock_select_i && $rose(reference_clock_o));
endmodule : ccso_monitor
bind ccso_top ccso_monitor u_mon (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .external_reference_input_i,
	.rtc_osc_i, .clock_select_i, .debug_clock_output_pin_oe_n_o, .debug_clock_output_slew_o,
	.reference_clock_o, .rtc_timer_clock_o);

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clock_select_i = 1'b1;
	logic [15:0] avs_address_i = 16'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic external_reference_input_i;
	logic rtc_osc_i;
	logic [3:0] gen_clk_i;
	logic debug_clock_output_pin_o;
	logic debug_clock_output_pin_oe_n_o;
	logic [1:0] debug_clock_output_slew_o;
	logic reference_clock_o;
	logic rtc_timer_clock_o;
	logic pll_bypass_o;
	logic [7:0] spi_clk_div_o;
	logic [7:0] i2c_clk_div_o;
	logic [31:0] v;
	logic [31:0] pt [8] = '{32'he, 32'h20, 32'h4, 32'h6, 32'h8, 32'ha, 32'h0, 32'h0};
	logic mon;
	int err_count = 0;
	int n_compared = 0;
	int probe = 0;
	assign mon = probe == 0 ? debug_clock_output_pin_o
		: (probe == 1 ? reference_clock_o : rtc_timer_clock_o);
	initial forever #10 mclk_i = ~mclk_i;
	ccso_clk_model u_src (.mclk_i, .sel_i(clock_select_i), .ext_o(external_reference_input_i),
		.rtc_o(rtc_osc_i), .gen_o(gen_clk_i));
	ccso_top dut (.mclk_i, .rst_i, .ce_i(1'b1), .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
		.external_reference_input_i, .rtc_osc_i, .clock_select_i, .gen_clk_i,
		.debug_clock_output_pin_o, .debug_clock_output_pin_oe_n_o, .debug_clock_output_slew_o,
		.reference_clock_o, .rtc_timer_clock_o, .pll_bypass_o, .spi_clk_div_o, .i2c_clk_div_o);
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [3:0] b);
		int i;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {16'h0, d};
		avs_byteenable_i <= b;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		v = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// one more edge so that outputs launched at completion have settled
		@(posedge mclk_i);
		if (i == 20)
		begin
			err_count++;
			complete_run();
		end
	endtask : xfer
	task rchk(input logic [15:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 16'h0, 4'hf);
		chk(nm, e, v);
	endtask : rchk
	// period between the first two rising edges, zero if the signal stays flat
	task mchk(input int s, input logic [31:0] e, input string nm);
		int n;
		int r;
		logic b;
		logic [31:0] p;
		p = 0;
		r = -1;
		probe = s;
		repeat (8) @(posedge mclk_i);
		b = mon;
		for (n = 0; n < 100; n++)
		begin
			@(posedge mclk_i);
			if (mon === 1'b1 && b === 1'b0 && r >= 0 && p == 0)
				p = 32'(n - r);
			if (mon === 1'b1 && b === 1'b0 && r < 0)
				r = n;
			b = mon;
		end
		chk(nm, e, p);
	endtask : mchk
	task boot;
		int i;
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 200 && debug_clock_output_pin_oe_n_o !== 1'b1; i++)
			@(posedge mclk_i);
		if (i == 200)
		begin
			err_count++;
			complete_run();
		end
	endtask : boot
	initial
	begin
		boot();
		rchk(16'h7060, 32'h4, "status three");
		rchk(16'h7068, 32'h7, "info");
		chk("bypass", 32'h1, 32'(pll_bypass_o));
		chk("spi div", 32'h18, 32'(spi_clk_div_o));
		chk("i2c div", 32'h1e, 32'(i2c_clk_div_o));
		$display("test boot done");
		xfer(1'b1, 16'h7058, 16'h3, 4'h1);
		chk("slew", 32'h3, 32'(debug_clock_output_slew_o));
		xfer(1'b1, 16'h7058, 16'h0, 4'h2);
		rchk(16'h7058, 32'h3, "slew lane");
		xfer(1'b1, 16'h7064, 16'h1234, 4'h3);
		chk("spi div", 32'h34, 32'(spi_clk_div_o));
		xfer(1'b1, 16'h7068, 16'h0, 4'h3);
		rchk(16'h7068, 32'h7, "info ro");
		xfer(1'b1, 16'h7070, 16'hffff, 4'h3);
		rchk(16'h7070, 32'h0, "unmapped");
		$display("test registers done");
		xfer(1'b1, 16'h7060, 16'h0, 4'h1);
		repeat (2) @(posedge mclk_i);
		chk("pin on", 32'h0, 32'(debug_clock_output_pin_oe_n_o));
		for (int s = 0; s < 8; s++)
		begin
			xfer(1'b1, 16'h705c, 16'(s), 4'h1);
			mchk(0, pt[s], "source period");
		end
		mchk(1, 32'he, "external reference");
		mchk(2, 32'h20, "timer clock");
		xfer(1'b1, 16'h7060, 16'h4, 4'h1);
		$display("test output done");
		rst_i <= 1'b1;
		clock_select_i <= 1'b0;
		boot();
		rchk(16'h7068, 32'h2, "info osc");
		chk("bypass osc", 32'h0, 32'(pll_bypass_o));
		chk("spi osc", 32'h0, 32'(spi_clk_div_o));
		mchk(1, 32'h20, "osc reference");
		$display("test oscillator done");
		complete_run();
	end
endmodule : tb
